// ### sard_pkg.sv
package sard_pkg;
  localparam int DATA_BITS = 18;
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS = 1600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] BIT_CNT_RESET = 6'h00;

  typedef enum logic {
    SARD_MODE_CHAIN,
    SARD_MODE_SELECT
  } sard_mode_t;

  typedef enum logic [1:0] {
    SARD_ST_IDLE,
    SARD_ST_CONVERT,
    SARD_ST_READY
  } sard_state_t;

  typedef struct packed {
    logic o;
    logic oe;
  } sard_pin_t;
endpackage

// ### sard_top.sv
`timescale 1ns/1ps
// How it works
// - Mode latched at each start rising edge.
// - Select high gives select, low gives chain.
// - Select tied to start resolves to chain.
// - Power down automatically after each conversion.
// - Three-wire select uses start, clock, data only.
// - Four-wire select input gates readback.
// - Chain mode feeds serial input into shifter.
// - Start edge converts on internal clock.
// - MSB first, shift on serial clock falls.
// - Select output floats after 18 falls or deselect.
module sard_top #(
  parameter int DATA_BITS = sard_pkg::DATA_BITS,
  parameter int CONV_CYCLES = sard_pkg::CONV_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_conversion_start_input,
  input wire logic i_serial_in_or_select_input,
  input wire logic i_sck,
  input wire logic [DATA_BITS-1:0] i_sample,
  output logic [DATA_BITS-1:0] o_sample_taken,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_powered_down,
  output logic o_mode_select
);

  // Refuse widths that the six-bit bit counter cannot serve.
  if (DATA_BITS < 2 || DATA_BITS > 63 || CONV_CYCLES < 1) begin
    $error("sard_top: unsupported parameter values.");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] prev;
  logic [2:0] next_sync1;
  logic [2:0] next_sync2;
  logic [2:0] next_prev;

  always_comb begin
    next_sync1 = {i_sck, i_serial_in_or_select_input, i_conversion_start_input};
    next_sync2 = sync1;
    next_prev = sync2;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      prev <= 3'h0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  logic conversion_start_input;
  logic sdi;
  logic cnv_rise;
  logic sck_fall;
  always_comb begin
    conversion_start_input = sync2[0];
    sdi = sync2[1];
    cnv_rise = sync2[0] & ~prev[0];
    sck_fall = ~sync2[2] & prev[2];
  end

  // The select level is taken from the cycle before the start edge, which gives the
  // select input a hold time: when select is wired to start it still reads low.
  logic sel_before;
  sard_pkg::sard_mode_t start_mode;
  always_comb begin
    sel_before = prev[1];
    if (sel_before) begin
      start_mode = sard_pkg::SARD_MODE_SELECT;
    end else begin
      start_mode = sard_pkg::SARD_MODE_CHAIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion, mode and readback state.
  sard_pkg::sard_state_t state;
  sard_pkg::sard_state_t next_state;
  sard_pkg::sard_mode_t mode;
  sard_pkg::sard_mode_t next_mode;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [DATA_BITS-1:0] shifter;
  logic [DATA_BITS-1:0] next_shifter;
  logic [DATA_BITS-1:0] taken;
  logic [DATA_BITS-1:0] next_taken;
  logic [5:0] bits;
  logic [5:0] next_bits;
  logic sdo;
  logic next_sdo;
  logic oe;
  logic next_oe;
  logic selected;

  // Select mode reads while the select condition holds: start low in three-wire,
  // select input low in four-wire (start then stays high).
  always_comb begin
    selected = conversion_start_input ? ~sdi : 1'b1;
  end

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_timer = timer;
    next_shifter = shifter;
    next_taken = taken;
    next_bits = bits;
    next_sdo = sdo;
    next_oe = oe;
    if (cnv_rise) begin
      next_mode = start_mode;
      next_state = sard_pkg::SARD_ST_CONVERT;
      next_timer = 32'h0;
      next_taken = i_sample;
      next_oe = ~sel_before;
      next_sdo = 1'b0;
      next_bits = sard_pkg::BIT_CNT_RESET;
    end else begin
      case (state)
        sard_pkg::SARD_ST_IDLE: begin
          if (mode == sard_pkg::SARD_MODE_CHAIN && !conversion_start_input && !sdi) begin
            next_oe = 1'b1;
            next_sdo = 1'b0;
          end
        end
        sard_pkg::SARD_ST_CONVERT: begin
          next_timer = timer + 32'h1;
          if (timer >= 32'(CONV_CYCLES - 1)) begin
            next_state = sard_pkg::SARD_ST_READY;
            next_shifter = taken;
            next_bits = sard_pkg::BIT_CNT_RESET;
            if (mode == sard_pkg::SARD_MODE_CHAIN) begin
              next_sdo = taken[DATA_BITS-1];
              next_oe = 1'b1;
            end
          end
        end
        sard_pkg::SARD_ST_READY: begin
          if (mode == sard_pkg::SARD_MODE_SELECT) begin
            if (!selected || bits >= 6'(DATA_BITS)) begin
              next_oe = 1'b0;
              if (!selected && bits != sard_pkg::BIT_CNT_RESET) begin
                next_state = sard_pkg::SARD_ST_IDLE;
              end
            end else begin
              next_oe = 1'b1;
              next_sdo = shifter[DATA_BITS-1];
              if (sck_fall) begin
                next_shifter = {shifter[DATA_BITS-2:0], 1'b0};
                next_sdo = shifter[DATA_BITS-2];
                next_bits = bits + 6'h1;
                if (bits + 6'h1 >= 6'(DATA_BITS)) begin
                  next_oe = 1'b0;
                end
              end
            end
          end else begin
            next_oe = 1'b1;
            if (sck_fall) begin
              next_shifter = {shifter[DATA_BITS-2:0], sdi};
              next_sdo = shifter[DATA_BITS-2];
            end
          end
        end
        default: begin
          next_state = sard_pkg::SARD_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= sard_pkg::SARD_ST_IDLE;
      mode <= sard_pkg::SARD_MODE_SELECT;
      timer <= 32'h0;
      shifter <= '0;
      taken <= '0;
      bits <= sard_pkg::BIT_CNT_RESET;
      sdo <= 1'b0;
      oe <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      timer <= next_timer;
      shifter <= next_shifter;
      taken <= next_taken;
      bits <= next_bits;
      sdo <= next_sdo;
      oe <= next_oe;
    end
  end

  // The data pin and its enable travel together.
  sard_pkg::sard_pin_t pin_out;
  always_comb begin
    pin_out.o = sdo;
    pin_out.oe = oe;
  end
  assign o_sdo = pin_out.o;
  assign o_sdo_oe = pin_out.oe;
  assign o_sample_taken = taken;
  assign o_powered_down = (state != sard_pkg::SARD_ST_CONVERT);
  assign o_mode_select = (mode == sard_pkg::SARD_MODE_SELECT);

endmodule

// ### sard_top_asserts.sv
`timescale 1ns/1ps
module sard_top_asserts #(
  parameter int DATA_BITS = 18,
  parameter int CONV_CYCLES = 320
) (
  input logic i_clk,
  input logic i_resetn,
  input logic i_conversion_start_input,
  input logic i_serial_in_or_select_input,
  input logic i_sck,
  input logic [DATA_BITS-1:0] o_sample_taken,
  input logic o_sdo,
  input logic o_sdo_oe,
  input logic o_powered_down,
  input logic o_mode_select
);
  localparam int LIM = CONV_CYCLES + 8;
  wire st = i_conversion_start_input;
  wire sl = i_serial_in_or_select_input;
  wire pd = o_powered_down;
  wire ms = o_mode_select;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  property p_conv; $fell(pd) |-> ##[1:LIM] pd; endproperty
  a_conv: assert property (p_conv) else $error("conv");
  property p_hiz; $fell(pd) && ms |=> (!o_sdo_oe) [*4]; endproperty
  a_hiz: assert property (p_hiz) else $error("hiz");
  property p_mode; $fell(pd) |=> ms == $past(sl, 7); endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_hold; $changed(ms) |-> !pd; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_take; $changed(o_sample_taken) |-> !pd; endproperty
  a_take: assert property (p_take) else $error("take");
  property p_desel; (ms && st && sl) [*6] |-> !o_sdo_oe; endproperty
  a_desel: assert property (p_desel) else $error("desel");
  property p_chain; $rose(pd) && !ms |-> ##[0:2] o_sdo_oe; endproperty
  a_chain: assert property (p_chain) else $error("chain");
  property p_shift; i_sck [*7] |-> $stable(o_sdo); endproperty
  a_shift: assert property (p_shift) else $error("shift");
endmodule

// ### sard_host.sv
`timescale 1ns/1ps
module sard_host (
  input logic i_clk,
  input logic i_sdo,
  output logic o_start,
  output logic o_sel,
  output logic o_sck
);
  initial {o_start, o_sel, o_sck} = 3'h2;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic pins(input logic s, input logic c);
    o_start <= s;
    o_sel <= c;
    tick(10);
  endtask
  task automatic conv(input logic c, input logic t, input int cyc);
    pins(1'b0, c);
    o_start <= 1'b1;
    if (t) o_sel <= 1'b1;
    tick(cyc + 10);
  endtask
  task automatic rd(input int n, input logic ch, input logic [35:0] d, output logic [35:0] q);
    q = 36'h0;
    for (int i = 0; i < n; i++) begin
      tick(7);
      @(negedge i_clk) q = {q[34:0], i_sdo};
      @(posedge i_clk) o_sck <= 1'b1;
      if (ch) o_sel <= d[35-i];
      tick(8);
      o_sck <= 1'b0;
    end
    tick(8);
  endtask
endmodule

// ### sard_top_bench.sv
`timescale 1ns/1ps
module sard_top_bench;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_conversion_start_input, i_serial_in_or_select_input, i_sck, o_sdo, o_sdo_oe, o_powered_down, o_mode_select;
  logic [17:0] i_sample = 18'h0;
  logic [17:0] o_sample_taken;
  logic [17:0] mq[$];
  logic [35:0] q, d;
  int fail_count = 0;
  int tests_run = 0;
  always #2.5 i_clk = ~i_clk;
  sard_host host_u (.i_clk(i_clk), .i_sdo(o_sdo), .o_start(i_conversion_start_input),
    .o_sel(i_serial_in_or_select_input), .o_sck(i_sck));
  sard_top #(.CONV_CYCLES(8)) dut_u (.*);
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic go(input logic c, input logic t);
    logic [17:0] v;
    v = 18'($urandom);
    i_sample <= v;
    mq.push_back(v);
    host_u.conv(c, t, 8);
    chk(36'(o_powered_down), 36'h1);
    chk(36'(o_sample_taken), 36'(v));
    chk(36'(o_mode_select), 36'(c));
  endtask
  initial begin
    void'($urandom(38));
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    go(1'b1, 1'b0);
    host_u.pins(1'b0, 1'b1);
    host_u.rd(18, 1'b0, d, q);
    chk(q, 36'(mq.pop_front()));
    chk(36'(o_sdo_oe), 36'h0);
    $display("three-wire done");
    go(1'b1, 1'b0);
    host_u.pins(1'b1, 1'b0);
    host_u.rd(9, 1'b0, d, q);
    host_u.pins(1'b1, 1'b1);
    chk(q, 36'(mq.pop_front() >> 9));
    chk(36'(o_sdo_oe), 36'h0);
    $display("four-wire done");
    d = 36'({$urandom, $urandom});
    go(1'b0, 1'b0);
    host_u.rd(36, 1'b1, d, q);
    chk(q, {mq.pop_front(), d[35:18]});
    $display("chain done");
    go(1'b0, 1'b1);
    $display("tied done");
    wrap_up();
  end
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule
bind sard_top sard_top_asserts #(.DATA_BITS(DATA_BITS), .CONV_CYCLES(CONV_CYCLES)) chk_u (.*);
